// ===== sts_pkg.sv
// Package for the startup self-test state sequencer.
// Assumes a single 250 MHz system clock and an active-low asynchronous reset.
package sts_pkg;

	localparam int          REF_CLK_MHZ     = 250;
	localparam int          ERR_DELAY_S     = 3;
	localparam int unsigned ERR_DELAY_CYC   = ERR_DELAY_S * REF_CLK_MHZ * 1000000;
	localparam int          ERR_CNT_W       = 30;
	localparam int          SYNC_STAGES     = 2;

	// Display codes driven to the display output.
	localparam logic [2:0]  DISP_NONE       = 3'h0;
	localparam logic [2:0]  DISP_INIT       = 3'h1;
	localparam logic [2:0]  DISP_ERROR      = 3'h2;
	localparam logic [2:0]  DISP_ONLINE     = 3'h3;
	localparam logic [2:0]  DISP_OFFLINE    = 3'h4;

	// Reasons latched on entry to the error state.
	localparam logic [3:0]  CAUSE_NONE      = 4'h0;
	localparam logic [3:0]  CAUSE_HW        = 4'h1;
	localparam logic [3:0]  CAUSE_SELF      = 4'h2;
	localparam logic [3:0]  CAUSE_INTEG     = 4'h3;
	localparam logic [3:0]  CAUSE_COND      = 4'h4;
	localparam logic [3:0]  CAUSE_EXT       = 4'h5;

	typedef enum logic [9:0] {
		ST_OFF     = 10'h001,
		ST_PWRON   = 10'h002,
		ST_HWTEST  = 10'h004,
		ST_SELF    = 10'h008,
		ST_INTEG   = 10'h010,
		ST_IDLE    = 10'h020,
		ST_ONLINE  = 10'h040,
		ST_OFFLINE = 10'h080,
		ST_ERROR   = 10'h100,
		ST_SPARE   = 10'h200
	} sts_state_t;

	// One-cycle pass and fail strobe from a test stage.
	typedef struct packed {
		logic pass;
		logic fail;
	} sts_result_t;

	// Hardware check fault sources.
	typedef struct packed {
		logic sensorInitFail;
		logic hardFault;
	} sts_hw_fault_t;

	// Self-test fault sources.
	typedef struct packed {
		logic knownAnswerMismatch;
		logic rngRepeat;
		logic keyPairMismatch;
	} sts_self_fault_t;

	// Outward request and output gating.
	typedef struct packed {
		logic usbReqEn;
		logic sensorReqEn;
		logic switchReqEn;
		logic usbTxEn;
		logic displayEn;
		logic approvedOpsEn;
		logic statusEn;
	} sts_gate_t;

endpackage : sts_pkg

// ===== sts_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/100ps
module sts_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule : sts_sync

// ===== sts_check_eval.sv
// Folds fault sources and a done strobe into one pass or fail strobe.
// Assumes faults and done are single-cycle strobes on ref_clk.
`timescale 1ns/100ps
module sts_check_eval #(
	parameter int NFAULT = 2
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              armed,
	input  wire logic              done,
	input  wire logic [NFAULT-1:0] faults,
	output sts_pkg::sts_result_t   result
);

	logic anyFault;

	assign anyFault = |faults;

	// A fault wins over a simultaneous done; the result is held one cycle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			result <= '0;
		end else begin
			result.fail <= armed & anyFault;
			result.pass <= armed & done & ~anyFault;
		end
	end

endmodule : sts_check_eval

// ===== sts_startup_sequencer.sv
// Top-level operating-state sequencer of the token device.
// Assumes test engines strobe done and faults on ref_clk; pin inputs are asynchronous.
`timescale 1ns/100ps
module sts_startup_sequencer #(
	parameter int unsigned ERR_DELAY = sts_pkg::ERR_DELAY_CYC
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic                   powerButton,
	input  wire logic                   usbAttached,
	input  wire logic                   initDone,
	input  wire logic                   hwTestDone,
	input  wire sts_pkg::sts_hw_fault_t hwFault,
	input  wire logic                   selfTestDone,
	input  wire sts_pkg::sts_self_fault_t selfFault,
	input  wire logic                   integDone,
	input  wire logic [31:0]            fwCheckValue,
	input  wire logic [31:0]            fwRefValue,
	input  wire logic                   condRngRepeat,
	input  wire logic                   condKeyPairMismatch,
	input  wire logic                   extError,
	input  wire logic                   hostPowerOff,
	input  wire logic                   usbReq,
	input  wire logic                   sensorReq,
	input  wire logic                   switchReq,
	output sts_pkg::sts_state_t         state,
	output logic                        hwTestStart,
	output logic                        selfTestStart,
	output logic                        integStart,
	output logic                        approvedMode,
	output logic                        approvedIcon,
	output logic [2:0]                  displayCode,
	output logic                        powerEnable,
	output logic [3:0]                  errorCause,
	output sts_pkg::sts_gate_t          gate,
	output logic                        usbReqTaken,
	output logic                        sensorReqTaken,
	output logic                        switchReqTaken
);

	sts_pkg::sts_state_t state_reg;
	sts_pkg::sts_state_t state_next;
	sts_pkg::sts_result_t hwResult;
	sts_pkg::sts_result_t selfResult;
	sts_pkg::sts_result_t integResult;
	logic [2:0]          pinSync;
	logic                buttonSync;
	logic                usbSync;
	logic                switchSync;
	logic                buttonPrev_reg;
	logic                buttonRise;
	logic                condFail;
	logic                integMismatch;
	logic                approved_reg;
	logic [3:0]          cause_reg;
	logic [3:0]          cause_next;
	logic [sts_pkg::ERR_CNT_W-1:0] errCnt_reg;
	logic                errDelayDone;
	logic                hwArmed;
	logic                selfArmed;
	logic                integArmed;
	logic [2:0]          disp_reg;

	sts_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.asyncIn ({powerButton, usbAttached, switchReq}),
		.syncOut (pinSync)
	);

	assign buttonSync = pinSync[2];
	assign usbSync    = pinSync[1];
	assign switchSync = pinSync[0];
	assign buttonRise = buttonSync & ~buttonPrev_reg;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			buttonPrev_reg <= 1'b0;
		end else begin
			buttonPrev_reg <= buttonSync;
		end
	end

	assign hwArmed    = (state_reg == sts_pkg::ST_HWTEST);
	assign selfArmed  = (state_reg == sts_pkg::ST_SELF);
	assign integArmed = (state_reg == sts_pkg::ST_INTEG);

	sts_check_eval #(
		.NFAULT(2)
	) u_hw_eval (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.armed   (hwArmed),
		.done    (hwTestDone),
		.faults  ({hwFault.sensorInitFail, hwFault.hardFault}),
		.result  (hwResult)
	);

	sts_check_eval #(
		.NFAULT(3)
	) u_self_eval (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.armed   (selfArmed),
		.done    (selfTestDone),
		.faults  ({selfFault.knownAnswerMismatch, selfFault.rngRepeat, selfFault.keyPairMismatch}),
		.result  (selfResult)
	);

	assign integMismatch = integDone & (fwCheckValue != fwRefValue);

	sts_check_eval #(
		.NFAULT(1)
	) u_integ_eval (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.armed   (integArmed),
		.done    (integDone),
		.faults  (integMismatch),
		.result  (integResult)
	);

	assign condFail = condRngRepeat | condKeyPairMismatch;

	assign errDelayDone = (errCnt_reg >= ERR_DELAY[sts_pkg::ERR_CNT_W-1:0] - 1'b1);

	always_comb begin
		state_next = state_reg;
		cause_next = sts_pkg::CAUSE_NONE;
		unique case (state_reg)
			sts_pkg::ST_OFF: begin
				if (buttonRise) begin
					state_next = sts_pkg::ST_PWRON;
				end
			end
			sts_pkg::ST_PWRON: begin
				if (initDone) begin
					state_next = sts_pkg::ST_HWTEST;
				end
			end
			sts_pkg::ST_HWTEST: begin
				if (hwResult.fail) begin
					state_next = sts_pkg::ST_ERROR;
					cause_next = sts_pkg::CAUSE_HW;
				end else if (hwResult.pass) begin
					state_next = sts_pkg::ST_SELF;
				end
			end
			sts_pkg::ST_SELF: begin
				if (selfResult.fail) begin
					state_next = sts_pkg::ST_ERROR;
					cause_next = sts_pkg::CAUSE_SELF;
				end else if (selfResult.pass) begin
					state_next = sts_pkg::ST_INTEG;
				end
			end
			sts_pkg::ST_INTEG: begin
				if (integResult.fail) begin
					state_next = sts_pkg::ST_ERROR;
					cause_next = sts_pkg::CAUSE_INTEG;
				end else if (integResult.pass) begin
					state_next = sts_pkg::ST_IDLE;
				end
			end
			sts_pkg::ST_IDLE: begin
				state_next = usbSync ? sts_pkg::ST_ONLINE : sts_pkg::ST_OFFLINE;
			end
			sts_pkg::ST_ONLINE: begin
				if (condFail) begin
					state_next = sts_pkg::ST_ERROR;
					cause_next = sts_pkg::CAUSE_COND;
				end else if (hostPowerOff) begin
					state_next = sts_pkg::ST_OFF;
				end else if (!usbSync) begin
					state_next = sts_pkg::ST_OFFLINE;
				end
			end
			sts_pkg::ST_OFFLINE: begin
				if (condFail) begin
					state_next = sts_pkg::ST_ERROR;
					cause_next = sts_pkg::CAUSE_COND;
				end else if (usbSync) begin
					state_next = sts_pkg::ST_ONLINE;
				end
			end
			sts_pkg::ST_ERROR: begin
				if (errDelayDone) begin
					state_next = sts_pkg::ST_OFF;
				end
			end
			default: begin
				state_next = sts_pkg::ST_ERROR;
				cause_next = sts_pkg::CAUSE_EXT;
			end
		endcase
		if (extError && state_reg != sts_pkg::ST_OFF && state_reg != sts_pkg::ST_ERROR) begin
			state_next = sts_pkg::ST_ERROR;
			cause_next = sts_pkg::CAUSE_EXT;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= sts_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cause_reg <= sts_pkg::CAUSE_NONE;
		end else if (state_next == sts_pkg::ST_ERROR && state_reg != sts_pkg::ST_ERROR) begin
			cause_reg <= cause_next;
		end else if (state_next == sts_pkg::ST_PWRON) begin
			cause_reg <= sts_pkg::CAUSE_NONE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			errCnt_reg <= '0;
		end else if (state_reg != sts_pkg::ST_ERROR) begin
			errCnt_reg <= '0;
		end else if (!errDelayDone) begin
			errCnt_reg <= errCnt_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			approved_reg <= 1'b0;
		end else if (state_next == sts_pkg::ST_ERROR || state_next == sts_pkg::ST_OFF
				|| state_next == sts_pkg::ST_PWRON) begin
			approved_reg <= 1'b0;
		end else if (state_reg == sts_pkg::ST_INTEG && state_next == sts_pkg::ST_IDLE) begin
			approved_reg <= 1'b1;
		end
	end

	// Start strobes fire in the first cycle of each test stage.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hwTestStart    <= 1'b0;
			selfTestStart  <= 1'b0;
			integStart     <= 1'b0;
		end else begin
			hwTestStart    <= (state_next == sts_pkg::ST_HWTEST) && (state_reg != sts_pkg::ST_HWTEST);
			selfTestStart  <= (state_next == sts_pkg::ST_SELF) && (state_reg != sts_pkg::ST_SELF);
			integStart     <= (state_next == sts_pkg::ST_INTEG) && (state_reg != sts_pkg::ST_INTEG);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			disp_reg <= sts_pkg::DISP_NONE;
		end else begin
			unique case (state_next)
				sts_pkg::ST_HWTEST:  disp_reg <= sts_pkg::DISP_INIT;
				sts_pkg::ST_ERROR:   disp_reg <= sts_pkg::DISP_ERROR;
				sts_pkg::ST_ONLINE:  disp_reg <= sts_pkg::DISP_ONLINE;
				sts_pkg::ST_OFFLINE: disp_reg <= sts_pkg::DISP_OFFLINE;
				default:             disp_reg <= sts_pkg::DISP_NONE;
			endcase
		end
	end

	always_comb begin
		gate               = '0;
		gate.usbReqEn      = approved_reg && (state_reg == sts_pkg::ST_ONLINE);
		gate.sensorReqEn   = approved_reg
			&& (state_reg == sts_pkg::ST_ONLINE || state_reg == sts_pkg::ST_OFFLINE);
		gate.switchReqEn   = (state_reg == sts_pkg::ST_ONLINE || state_reg == sts_pkg::ST_OFFLINE);
		gate.usbTxEn       = approved_reg && (state_reg == sts_pkg::ST_ONLINE);
		gate.displayEn     = (state_reg != sts_pkg::ST_SELF) && (state_reg != sts_pkg::ST_OFF);
		gate.approvedOpsEn = approved_reg && (state_reg != sts_pkg::ST_ERROR);
		gate.statusEn      = (state_reg != sts_pkg::ST_OFF);
	end

	assign usbReqTaken    = usbReq & gate.usbReqEn;
	assign sensorReqTaken = sensorReq & gate.sensorReqEn;
	assign switchReqTaken = switchSync & gate.switchReqEn;

	assign state        = state_reg;
	assign approvedMode = approved_reg;
	assign approvedIcon = approved_reg & gate.displayEn;
	assign displayCode  = gate.displayEn ? disp_reg : sts_pkg::DISP_NONE;
	assign powerEnable  = (state_reg != sts_pkg::ST_OFF);
	assign errorCause   = cause_reg;

endmodule : sts_startup_sequencer

// ===== sts_startup_sequencer_monitor.sv
// Concurrent checks on the ports of the startup sequencer.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module sts_startup_sequencer_monitor #(
	parameter int unsigned ERR_DELAY = 20
) (
	input wire logic                     ref_clk,
	input wire logic                     rst_b,
	input wire sts_pkg::sts_hw_fault_t   hwFault,
	input wire sts_pkg::sts_self_fault_t selfFault,
	input wire logic                     integDone,
	input wire logic [31:0]              fwCheckValue,
	input wire logic [31:0]              fwRefValue,
	input wire logic                     extError,
	input wire sts_pkg::sts_state_t      state,
	input wire logic                     approvedMode,
	input wire logic                     approvedIcon,
	input wire logic [2:0]               displayCode,
	input wire sts_pkg::sts_gate_t       gate,
	input wire logic                     usbReqTaken,
	input wire logic                     sensorReqTaken,
	input wire logic                     switchReqTaken
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	logic [31:0] errCnt_reg;

	// Counts the cycles spent in the error state so far.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			errCnt_reg <= 32'h0;
		end else begin
			errCnt_reg <= (state == sts_pkg::ST_ERROR) ? errCnt_reg + 32'h1 : 32'h0;
		end
	end

	chk_one_hot: assert property ($onehot(state)) else $error("state not one-hot");
	chk_self_quiet: assert property (state == sts_pkg::ST_SELF |-> !(usbReqTaken | sensorReqTaken
		| switchReqTaken | gate.usbTxEn | gate.displayEn) && displayCode == 3'h0) else $error("self quiet");
	chk_hw_fail: assert property (state == sts_pkg::ST_HWTEST && hwFault != 2'h0
		|-> ##[1:3] state == sts_pkg::ST_ERROR) else $error("hw fault missed");
	chk_self_fail: assert property (state == sts_pkg::ST_SELF && selfFault != 3'h0
		|-> ##[1:3] state == sts_pkg::ST_ERROR) else $error("self fault missed");
	chk_integ_pass: assert property (state == sts_pkg::ST_INTEG && integDone && !extError
		&& fwCheckValue == fwRefValue |-> ##[1:3] state == sts_pkg::ST_IDLE && approvedMode)
		else $error("integrity pass missed");
	chk_integ_fail: assert property (state == sts_pkg::ST_INTEG && integDone
		&& fwCheckValue != fwRefValue |-> ##[1:3] state == sts_pkg::ST_ERROR && !approvedMode)
		else $error("integrity fail missed");
	chk_error_quiet: assert property (state == sts_pkg::ST_ERROR && $past(state) == sts_pkg::ST_ERROR
		|-> !approvedMode && !gate.approvedOpsEn && gate.statusEn && displayCode == sts_pkg::DISP_ERROR)
		else $error("error state outputs");
	chk_icon_flag: assert property (approvedIcon == (approvedMode && gate.displayEn))
		else $error("icon mismatch");
	chk_err_delay: assert property ($past(state) == sts_pkg::ST_ERROR && state != sts_pkg::ST_ERROR
		|-> state == sts_pkg::ST_OFF && $past(errCnt_reg) + 32'h1 == ERR_DELAY)
		else $error("error delay length wrong");
	chk_err_bound: assert property (state == sts_pkg::ST_ERROR |-> errCnt_reg < ERR_DELAY)
		else $error("error delay overrun");
	chk_ext_error: assert property (extError && !(state inside {sts_pkg::ST_OFF, sts_pkg::ST_ERROR})
		|-> ##[1:3] state == sts_pkg::ST_ERROR) else $error("error not entered");

	cover property (state == sts_pkg::ST_ONLINE);
	cover property (state == sts_pkg::ST_OFFLINE);
	cover property ($past(state) == sts_pkg::ST_ERROR && state == sts_pkg::ST_OFF);
endmodule : sts_startup_sequencer_monitor

// ===== sts_host_model.sv
// Host applet model on the USB link: attach, requests, power-off command.
// Assumes the bench commands attach and power-off in step with ref_clk.
`timescale 1ns/100ps
module sts_host_model (
	input  wire logic ref_clk,
	input  wire logic plugIn,
	input  wire logic sendOff,
	output logic      usbAttached,
	output logic      usbReq,
	output logic      hostPowerOff
);
	// Commands are sampled on the edge and driven shortly after it.
	always @(posedge ref_clk) begin : drive
		logic p;
		logic o;
		p = plugIn;
		o = sendOff;
		#1;
		usbAttached = p;
		usbReq = p & 1'($urandom);
		hostPowerOff = o & p;
	end
endmodule : sts_host_model

// ===== sts_startup_sequencer_tb.sv
// Self-checking bench for the startup sequencer with a host model on USB.
// Assumes a 250 MHz clock and a shortened error delay.
`timescale 1ns/100ps
module sts_startup_sequencer_tb;
	localparam int unsigned ERR_DLY = 20;
	logic                     ref_clk = 1'b0;
	logic                     rst_b = 1'b0;
	logic                     powerButton = 1'b0;
	logic                     initDone = 1'b0;
	logic                     hwTestDone = 1'b0;
	sts_pkg::sts_hw_fault_t   hwFault = '0;
	logic                     selfTestDone = 1'b0;
	sts_pkg::sts_self_fault_t selfFault = '0;
	logic                     integDone = 1'b0;
	logic [31:0]              fwCheckValue = 32'h0;
	logic [31:0]              fwRefValue = 32'h0;
	logic                     condRngRepeat = 1'b0;
	logic                     condKeyPairMismatch = 1'b0;
	logic                     extError = 1'b0;
	logic                     sensorReq = 1'b0;
	logic                     switchReq = 1'b0;
	logic                     plugIn = 1'b0;
	logic                     sendOff = 1'b0;
	logic                     usbAttached, usbReq, hostPowerOff, approvedMode, approvedIcon;
	logic                     usbReqTaken, sensorReqTaken, switchReqTaken;
	logic [2:0]               displayCode;
	logic                     hwTestStart, selfTestStart, integStart, powerEnable;
	logic [3:0]               errorCause;
	int                       expCause[$];
	sts_pkg::sts_state_t      state;
	sts_pkg::sts_gate_t       gate;
	int                       err_count = 0;
	int                       compares = 0;

	always #2 ref_clk = ~ref_clk;

	sts_host_model sts_host_model_inst (
		.ref_clk      (ref_clk),
		.plugIn       (plugIn),
		.sendOff      (sendOff),
		.usbAttached  (usbAttached),
		.usbReq       (usbReq),
		.hostPowerOff (hostPowerOff)
	);

	sts_startup_sequencer #(
		.ERR_DELAY(ERR_DLY)
	) sts_startup_sequencer_inst (
		.ref_clk             (ref_clk),
		.rst_b               (rst_b),
		.powerButton         (powerButton),
		.usbAttached         (usbAttached),
		.initDone            (initDone),
		.hwTestDone          (hwTestDone),
		.hwFault             (hwFault),
		.selfTestDone        (selfTestDone),
		.selfFault           (selfFault),
		.integDone           (integDone),
		.fwCheckValue        (fwCheckValue),
		.fwRefValue          (fwRefValue),
		.condRngRepeat       (condRngRepeat),
		.condKeyPairMismatch (condKeyPairMismatch),
		.extError            (extError),
		.hostPowerOff        (hostPowerOff),
		.usbReq              (usbReq),
		.sensorReq           (sensorReq),
		.switchReq           (switchReq),
		.state               (state),
		.hwTestStart         (hwTestStart),
		.selfTestStart       (selfTestStart),
		.integStart          (integStart),
		.approvedMode        (approvedMode),
		.approvedIcon        (approvedIcon),
		.displayCode         (displayCode),
		.powerEnable         (powerEnable),
		.errorCause          (errorCause),
		.gate                (gate),
		.usbReqTaken         (usbReqTaken),
		.sensorReqTaken      (sensorReqTaken),
		.switchReqTaken      (switchReqTaken)
	);

	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask : step

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_st(input sts_pkg::sts_state_t exp, input int lim);
		for (int i = 0; i < lim && state !== exp; i++) begin
			step;
		end
		chk(state, exp);
	endtask : wait_st

	// Kind k: 0-1 hardware fault bit, 2-4 self-test fault bit, 5 bad image, 6 all pass.
	task automatic boot(input int k, input logic host);
		logic [31:0] v;
		v = $urandom;
		plugIn = host;
		powerButton = 1'b1;
		wait_st(sts_pkg::ST_PWRON, 8);
		powerButton = 1'b0;
		initDone = 1'b1;
		wait_st(sts_pkg::ST_HWTEST, 4);
		chk(hwTestStart, 10'h1);
		initDone = 1'b0;
		step;
		chk(displayCode, sts_pkg::DISP_INIT);
		hwFault = 2'(k < 2 ? 1 << k : 0);
		hwTestDone = 1'b1;
		step;
		hwFault = '0;
		hwTestDone = 1'b0;
		if (k < 2) return;
		wait_st(sts_pkg::ST_SELF, 4);
		chk(selfTestStart, 10'h1);
		sensorReq = 1'b1;
		switchReq = 1'b1;
		repeat (4) step;
		chk({usbReqTaken, sensorReqTaken, switchReqTaken, displayCode}, 10'h0);
		sensorReq = 1'b0;
		switchReq = 1'b0;
		selfFault = 3'(k > 1 && k < 5 ? 1 << (k - 2) : 0);
		selfTestDone = 1'b1;
		step;
		selfFault = '0;
		selfTestDone = 1'b0;
		if (k < 5) return;
		wait_st(sts_pkg::ST_INTEG, 4);
		chk(integStart, 10'h1);
		fwCheckValue = v;
		fwRefValue = k == 5 ? ~v : v;
		integDone = 1'b1;
		step;
		integDone = 1'b0;
	endtask : boot

	task automatic err_tail;
		wait_st(sts_pkg::ST_ERROR, 4);
		chk(errorCause, 10'(expCause.pop_front()));
		step;
		chk({gate.approvedOpsEn, gate.statusEn, approvedMode, powerEnable, displayCode},
			{4'h5, sts_pkg::DISP_ERROR});
		repeat (ERR_DLY - 4) step;
		chk(state, sts_pkg::ST_ERROR);
		wait_st(sts_pkg::ST_OFF, 6);
		chk(powerEnable, 10'h0);
	endtask : err_tail

	task automatic summarize;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		#200000;
		err_count++;
		summarize;
	end

	initial begin
		void'($urandom(32'he0e8ec49));
		repeat (5) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		chk(state, sts_pkg::ST_OFF);
		for (int k = 0; k < 6; k++) begin
			expCause.push_back(k < 2 ? sts_pkg::CAUSE_HW
				: k < 5 ? sts_pkg::CAUSE_SELF : sts_pkg::CAUSE_INTEG);
			boot(k, 1'($urandom));
			err_tail;
		end
		for (int j = 0; j < 4; j++) begin
			boot(6, j != 3);
			wait_st(j == 3 ? sts_pkg::ST_OFFLINE : sts_pkg::ST_ONLINE, 6);
			chk({approvedMode, approvedIcon}, 10'h3);
			#1;
			chk(usbReqTaken, usbReq);
			step;
			case (j)
				0: condRngRepeat = 1'b1;
				1: condKeyPairMismatch = 1'b1;
				2: sendOff = 1'b1;
				default: extError = 1'b1;
			endcase
			if (j != 2) begin
				expCause.push_back(j == 3 ? sts_pkg::CAUSE_EXT : sts_pkg::CAUSE_COND);
			end
			step;
			{condRngRepeat, condKeyPairMismatch, sendOff, extError} = 4'h0;
			if (j == 2) begin
				wait_st(sts_pkg::ST_OFF, 6);
			end else begin
				err_tail;
			end
		end
		summarize;
	end
endmodule : sts_startup_sequencer_tb

bind sts_startup_sequencer sts_startup_sequencer_monitor #(
	.ERR_DELAY(ERR_DELAY)
) sts_startup_sequencer_monitor_inst (
	.ref_clk        (ref_clk),
	.rst_b          (rst_b),
	.hwFault        (hwFault),
	.selfFault      (selfFault),
	.integDone      (integDone),
	.fwCheckValue   (fwCheckValue),
	.fwRefValue     (fwRefValue),
	.extError       (extError),
	.state          (state),
	.approvedMode   (approvedMode),
	.approvedIcon   (approvedIcon),
	.displayCode    (displayCode),
	.gate           (gate),
	.usbReqTaken    (usbReqTaken),
	.sensorReqTaken (sensorReqTaken),
	.switchReqTaken (switchReqTaken)
);
